// ### logic/flash_cfg_pkg.sv
package flash_cfg_pkg;

    // core clock and default programming time
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CFG_WRITE_TIME_NS_DEF = 50000;

    // opcodes and unlock sequence bytes
    localparam logic [7:0] OP_CFG_READ = 8'h3F;
    localparam logic [7:0] SEQ_B1 = 8'h3D;
    localparam logic [7:0] SEQ_B2 = 8'h2A;
    localparam logic [7:0] SEQ_B3 = 8'h81;
    localparam logic [7:0] SEQ_B4_EN = 8'h66;
    localparam logic [7:0] SEQ_B4_DIS = 8'h67;

    // configuration byte layout
    localparam int unsigned QUAD_EN_POS = 7;
    localparam logic [7:0] CFG_RSVD_VALUE = 8'h08;
    localparam logic QUAD_EN_FACTORY = 1'b0;

    // serial bit counting
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [5:0] SEQ_BITS = 6'h20;
    localparam logic [5:0] BIT_CNT_MAX = 6'h21;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [1:0] SEQ_LAST_IDX = 2'h3;

    // lifetime write counter
    localparam int unsigned WEAR_W = 14;
    localparam logic [WEAR_W-1:0] WEAR_LIMIT = 14'h2710;

    // core-side synchroniser lanes
    localparam int unsigned SYNC_N = 4;
    localparam int unsigned SY_CS = 0;
    localparam int unsigned SY_EN = 1;
    localparam int unsigned SY_DIS = 2;
    localparam int unsigned SY_OVR = 3;
    localparam logic [SYNC_N-1:0] SYNC_RST = 4'h1;

    localparam int unsigned CNT_W = 20;
    localparam int unsigned PROG_MIN_CYCLES = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PROG = 3'b010,
        ST_COMMIT = 3'b100
    } prog_state_type;

    function automatic logic [7:0] seq_byte(input logic [1:0] idx);
        logic [7:0] b;
        b = SEQ_B1;
        if (idx == 2'h1) begin
            b = SEQ_B2;
        end else if (idx == 2'h2) begin
            b = SEQ_B3;
        end
        return b;
    endfunction

endpackage

// ### logic/spi_link_if.sv
`timescale 1ns/10ps

interface spi_link_if;
    logic quad_en_level;
    logic en_ok;
    logic dis_ok;
    logic overrun;
    logic so_bit;
    logic so_oe;

    modport core (
        output quad_en_level,
        input en_ok,
        input dis_ok,
        input overrun,
        input so_bit,
        input so_oe
    );

    modport link (
        input quad_en_level,
        output en_ok,
        output dis_ok,
        output overrun,
        output so_bit,
        output so_oe
    );
endinterface

// ### logic/qe_nv_cell.sv
`timescale 1ns/10ps

module quad_en_nv_cell
    import flash_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic factory_init,
    input wire logic wr_stb,
    input wire logic wr_val,
    output logic quad_en,
    output logic wear_limit
);

    typedef struct packed {
        logic quad_en;
        logic [WEAR_W-1:0] wear;
        logic limit;
    } nv_state_type;

    nv_state_type nv_r;
    nv_state_type nv_nxt;

    // only a factory clear resets the cell; system reset never reaches it
    always_comb begin
        nv_nxt = nv_r;
        if (wr_stb) begin
            nv_nxt.quad_en = wr_val;
            if (nv_r.wear != WEAR_LIMIT) begin
                nv_nxt.wear = nv_r.wear + 14'h0001;
            end
        end
        nv_nxt.limit = (nv_nxt.wear == WEAR_LIMIT);
    end

    always_ff @(posedge core_clk or posedge factory_init) begin
        if (factory_init) begin
            nv_r <= '{quad_en: QUAD_EN_FACTORY, wear: '0, limit: 1'b0};
        end else begin
            nv_r <= nv_nxt;
        end
    end

    assign quad_en = nv_r.quad_en;
    assign wear_limit = nv_r.limit;

endmodule // quad_en_nv_cell

// ### logic/spi_frame_link.sv
`timescale 1ns/10ps

module spi_frame_link
    import flash_cfg_pkg::*;
(
    input wire logic sclk,
    input wire logic frame_rst,
    input wire logic si,
    spi_link_if.link lk
);

    typedef struct packed {
        logic [5:0] bit_cnt;
        logic [7:0] shreg;
        logic match;
        logic read_mode;
        logic en_ok;
        logic dis_ok;
        logic ovr;
        logic quad_s1;
        logic quad_s2;
        logic quad_s3;
        logic quad_lvl;
    } link_state_type;

    typedef struct packed {
        logic so_bit;
        logic so_oe;
        logic [2:0] out_idx;
    } so_state_type;

    link_state_type lk_r;
    link_state_type lk_nxt;
    so_state_type so_r;
    so_state_type so_nxt;

    // the frame reset ends everything with the frame, since sclk may stop
    always_comb begin
        logic [7:0] sh;
        sh = {lk_r.shreg[6:0], si};
        lk_nxt = lk_r;
        lk_nxt.shreg = sh;
        lk_nxt.quad_s1 = lk.quad_en_level;
        lk_nxt.quad_s2 = lk_r.quad_s1;
        lk_nxt.quad_s3 = lk_r.quad_s2;
        if (lk_r.quad_s2 == lk_r.quad_s3) begin
            lk_nxt.quad_lvl = lk_r.quad_s3;
        end
        if (lk_r.bit_cnt != BIT_CNT_MAX) begin
            lk_nxt.bit_cnt = lk_r.bit_cnt + 6'h01;
        end
        if (lk_r.bit_cnt[2:0] == BYTE_LAST && lk_r.bit_cnt < SEQ_BITS) begin
            if (lk_r.bit_cnt == OPCODE_LAST) begin
                lk_nxt.read_mode = (sh == OP_CFG_READ);
            end
            if (lk_r.bit_cnt[4:3] != SEQ_LAST_IDX) begin
                lk_nxt.match = (lk_r.bit_cnt == OPCODE_LAST || lk_r.match) &&
                               (sh == seq_byte(lk_r.bit_cnt[4:3]));
            end else begin
                lk_nxt.en_ok = lk_r.match && (sh == SEQ_B4_EN);
                lk_nxt.dis_ok = lk_r.match && (sh == SEQ_B4_DIS);
            end
        end
        // a bit beyond the 32nd spoils the sequence
        if (lk_r.bit_cnt == SEQ_BITS) begin
            lk_nxt.ovr = 1'b1;
            lk_nxt.en_ok = 1'b0;
            lk_nxt.dis_ok = 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // output shifts on the falling edge so the host samples on the rising one
    always_comb begin
        logic [7:0] cfg;
        cfg = CFG_RSVD_VALUE;
        cfg[QUAD_EN_POS] = lk_r.quad_lvl;
        so_nxt = so_r;
        if (lk_r.read_mode) begin
            so_nxt.so_oe = 1'b1;
            so_nxt.so_bit = cfg[BYTE_LAST - so_r.out_idx];
            so_nxt.out_idx = so_r.out_idx + 3'h1; // wraps: byte repeats
        end
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            so_r <= '0; // cs high floats the output at once
        end else begin
            so_r <= so_nxt;
        end
    end

    assign lk.en_ok = lk_r.en_ok;
    assign lk.dis_ok = lk_r.dis_ok;
    assign lk.overrun = lk_r.ovr;
    assign lk.so_bit = so_r.so_bit;
    assign lk.so_oe = so_r.so_oe;

endmodule // spi_frame_link

// ### logic/flash_quad_cfg.sv
`timescale 1ns/10ps

// What this block does
// - config read is only meaningful while ready; host checks ready first
// - after opcode 3Fh under chip select, config byte shifts out on SO
// - the same config byte repeats while chip select stays low and clock runs
// - chip select high ends the read at once and floats SO
// - config contents survive power cycles and power-on reset
// - bit 7 is quad enable: 1 enables quad commands, disables pin controls
// - reserved bits read only: 6:4 zero, 3 one, 2:0 zero
// - quad enable and disable touch only bit 7
// - quad enable set turns the two control pins into data lines 2 and 3
// - quad enable clear rejects quad opcodes; pins keep control roles
// - software reset leaves quad enable as it is
// - shipped parts hold quad enable at zero
// - config programming is self-timed within write time; status shows busy
// - sequence 3Dh 2Ah 81h 66h programs quad enable to one
// - sequence 3Dh 2Ah 81h 67h programs quad enable to zero
// - chip select rising after the 32nd bit starts the update
// - ready flag reads zero while busy, one when ready

module flash_quad_cfg
    import flash_cfg_pkg::*;
#(
    parameter int unsigned CFG_WRITE_TIME_NS = CFG_WRITE_TIME_NS_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic factory_init,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic soft_reset_cmd,
    input wire logic quad_opcode_hit,
    output logic so_out,
    output logic so_oe,
    output logic ready_flag,
    output logic quad_io_enable_bit,
    output logic pin_ctrl_en,
    output logic io23_data_en,
    output logic quad_cmd_accept,
    output logic quad_cmd_reject,
    output logic [7:0] cfg_byte,
    output logic wear_limit
);

    // a longest time: round down, but keep room for the commit cycle
    localparam int unsigned WRITE_CYCLES_RAW = CFG_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYCLES = (WRITE_CYCLES_RAW < PROG_MIN_CYCLES) ?
        PROG_MIN_CYCLES : WRITE_CYCLES_RAW;
    localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(WRITE_CYCLES - PROG_MIN_CYCLES);

    typedef struct packed {
        logic [SYNC_N-1:0] s1;
        logic [SYNC_N-1:0] s2;
        logic [SYNC_N-1:0] s3;
        logic [SYNC_N-1:0] lvl;
        logic [SYNC_N-1:0] prev;
        prog_state_type state;
        logic [CNT_W-1:0] cnt;
        logic armed_en;
        logic armed_dis;
        logic tgt_val;
        logic wr_stb;
        logic ready;
        logic quad_out;
        logic pin_ctrl;
        logic io23;
        logic acc;
        logic rej;
        logic [7:0] cfg;
    } core_state_type;

    localparam core_state_type CORE_RST = '{
        s1: SYNC_RST,
        s2: SYNC_RST,
        s3: SYNC_RST,
        lvl: SYNC_RST,
        prev: SYNC_RST,
        state: ST_IDLE,
        cnt: '0,
        armed_en: 1'b0,
        armed_dis: 1'b0,
        tgt_val: 1'b0,
        wr_stb: 1'b0,
        ready: 1'b1,
        quad_out: 1'b0,
        pin_ctrl: 1'b1,
        io23: 1'b0,
        acc: 1'b0,
        rej: 1'b0,
        cfg: CFG_RSVD_VALUE
    };

    core_state_type st_r;
    core_state_type st_nxt;

    spi_link_if lk ();

    logic frame_rst;
    logic nv_quad;
    logic nv_limit;
    logic [SYNC_N-1:0] raw_in;
    logic [SYNC_N-1:0] rise;
    logic [SYNC_N-1:0] fall;

    // the link side is held in reset whenever the frame is closed
    assign frame_rst = rst | cs_n;

    spi_frame_link u_link (
        .sclk(sclk),
        .frame_rst(frame_rst),
        .si(si),
        .lk(lk.link)
    );

    quad_en_nv_cell u_nv (
        .core_clk(core_clk),
        .factory_init(factory_init),
        .wr_stb(st_r.wr_stb),
        .wr_val(st_r.tgt_val),
        .quad_en(nv_quad),
        .wear_limit(nv_limit)
    );

    assign raw_in[SY_CS] = cs_n;
    assign raw_in[SY_EN] = lk.en_ok;
    assign raw_in[SY_DIS] = lk.dis_ok;
    assign raw_in[SY_OVR] = lk.overrun;

    assign rise = st_r.lvl & ~st_r.prev;
    assign fall = ~st_r.lvl & st_r.prev;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_stb = 1'b0;

        // three-stage synchronisers; a change counts once stages two and three agree
        st_nxt.s1 = raw_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.prev = st_r.lvl;
        for (int i = 0; i < SYNC_N; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end

        // a new frame forgets any sequence seen before it
        if (fall[SY_CS]) begin
            st_nxt.armed_en = 1'b0;
            st_nxt.armed_dis = 1'b0;
        end
        // link flags drop with cs, so only their rising edges arm or disarm
        if (rise[SY_OVR]) begin
            st_nxt.armed_en = 1'b0;
            st_nxt.armed_dis = 1'b0;
        end
        if (rise[SY_EN]) begin
            st_nxt.armed_en = 1'b1;
            st_nxt.armed_dis = 1'b0;
        end
        if (rise[SY_DIS]) begin
            st_nxt.armed_dis = 1'b1;
            st_nxt.armed_en = 1'b0;
        end

        unique case (st_r.state)
            ST_IDLE: begin
                // cs rising after a complete sequence starts the update
                if (rise[SY_CS] && (st_r.armed_en || st_r.armed_dis)) begin
                    st_nxt.state = ST_PROG;
                    st_nxt.tgt_val = st_r.armed_en;
                    st_nxt.cnt = PROG_LOAD;
                    st_nxt.ready = 1'b0;
                end
                if (rise[SY_CS]) begin
                    st_nxt.armed_en = 1'b0;
                    st_nxt.armed_dis = 1'b0;
                end
            end
            ST_PROG: begin
                // frames closed while busy are dropped, not queued
                if (rise[SY_CS]) begin
                    st_nxt.armed_en = 1'b0;
                    st_nxt.armed_dis = 1'b0;
                end
                if (st_r.cnt == '0) begin
                    st_nxt.state = ST_COMMIT;
                    st_nxt.wr_stb = 1'b1; // only bit 7 is written
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_W'(1);
                end
            end
            ST_COMMIT: begin
                if (rise[SY_CS]) begin
                    st_nxt.armed_en = 1'b0;
                    st_nxt.armed_dis = 1'b0;
                end
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
            end
            default: begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase

        // software reset is a device command that never reaches the cell
        if (soft_reset_cmd) begin
            st_nxt.armed_en = 1'b0;
            st_nxt.armed_dis = 1'b0;
        end

        // pin roles and command gating follow the stored bit
        st_nxt.quad_out = nv_quad;
        st_nxt.pin_ctrl = ~nv_quad;
        st_nxt.io23 = nv_quad;
        // gate on the bit the outputs show, so a commit edge never splits the answer
        st_nxt.acc = quad_opcode_hit & st_r.quad_out;
        st_nxt.rej = quad_opcode_hit & ~st_r.quad_out;
        st_nxt.cfg = CFG_RSVD_VALUE;
        st_nxt.cfg[QUAD_EN_POS] = nv_quad;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= CORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // the link reads the stored bit through its own synchroniser
    assign lk.quad_en_level = st_r.quad_out;

    assign so_out = lk.so_bit;
    assign so_oe = lk.so_oe;
    assign ready_flag = st_r.ready; // host gates config reads on this
    assign quad_io_enable_bit = st_r.quad_out;
    assign pin_ctrl_en = st_r.pin_ctrl;
    assign io23_data_en = st_r.io23;
    assign quad_cmd_accept = st_r.acc;
    assign quad_cmd_reject = st_r.rej;
    assign cfg_byte = st_r.cfg;
    assign wear_limit = nv_limit;

endmodule // flash_quad_cfg

// ### verif/qe_chk_monitor.sv
`timescale 1ns/10ps

module quad_cfg_monitor
    import flash_cfg_pkg::*;
#(
    parameter int unsigned CFG_WRITE_TIME_NS = CFG_WRITE_TIME_NS_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic quad_opcode_hit,
    input wire logic so_oe,
    input wire logic ready_flag,
    input wire logic quad_io_enable_bit,
    input wire logic pin_ctrl_en,
    input wire logic io23_data_en,
    input wire logic quad_cmd_accept,
    input wire logic quad_cmd_reject,
    input wire logic [7:0] cfg_byte
);
    localparam int WRITE_RAW = CFG_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_RAW < 2) ? 2 : WRITE_RAW;
    // busy span is far beyond any repetition count, so it is counted here
    logic [19:0] busy_cnt_r;
    logic [19:0] busy_cnt_nxt;
    always_comb begin
        busy_cnt_nxt = ready_flag ? 20'h00000 : busy_cnt_r + 20'h00001;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_r <= 20'h00000;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_cfg_layout: assert property (cfg_byte == {quad_io_enable_bit, 7'h08})
        else $error("config byte layout wrong");
    chk_pin_roles: assert property (
        pin_ctrl_en == !quad_io_enable_bit && io23_data_en == quad_io_enable_bit)
        else $error("pin roles disagree with quad enable");
    chk_hit_answer: assert property (quad_opcode_hit |=>
        quad_cmd_accept == $past(quad_io_enable_bit)
        && quad_cmd_reject == !$past(quad_io_enable_bit))
        else $error("quad opcode answer wrong");
    chk_pulse_cause: assert property (
        (quad_cmd_accept || quad_cmd_reject) |-> $past(quad_opcode_hit))
        else $error("quad answer without opcode");
    chk_quad_commit: assert property (
        $changed(quad_io_enable_bit) && !$past(rst) && !$past(rst, 2)
        |-> $past(ready_flag) && !$past(ready_flag, 2))
        else $error("quad enable changed outside a commit");
    chk_busy_length: assert property ($rose(ready_flag) |-> busy_cnt_r == WRITE_CYCLES)
        else $error("busy length wrong");
    chk_busy_start: assert property ($fell(ready_flag) |-> $past(cs_n, 3) && cs_n)
        else $error("busy began without frame end");
    chk_so_float: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");

    cover property ($fell(ready_flag));
    cover property (quad_cmd_accept);
    cover property (quad_cmd_reject);
    cover property (so_oe);
endmodule // quad_cfg_monitor

bind flash_quad_cfg quad_cfg_monitor #(.CFG_WRITE_TIME_NS(CFG_WRITE_TIME_NS)) u_mon (
    .core_clk, .rst, .cs_n, .quad_opcode_hit, .so_oe, .ready_flag, .quad_io_enable_bit,
    .pin_ctrl_en, .io23_data_en, .quad_cmd_accept, .quad_cmd_reject, .cfg_byte
);

// ### verif/spi_host_model.sv
`timescale 1ns/10ps

module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // mode 0; clock stands low between frames; odd offset keeps edges off core_clk
    task automatic frame(input logic [39:0] d, input int n, input int nrd,
                         output logic [15:0] rd);
        rd = 16'h0000;
        #1.3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i]; // msb first
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        si = ~si;
        for (int i = 0; i < nrd; i++) begin
            #62.5 sclk = 1'b1;
            rd = {rd[14:0], so_oe ? so_out : 1'bz}; // up to two bytes kept
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1; // deselect after last bit
        si = ~si;
    endtask
endmodule // spi_host_model

// ### verif/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    import flash_cfg_pkg::*;
    logic core_clk, rst, factory_init, soft_reset_cmd, quad_opcode_hit;
    logic sclk, cs_n, si, so_out, so_oe, ready_flag, quad_io_enable_bit;
    logic pin_ctrl_en, io23_data_en, quad_cmd_accept, quad_cmd_reject, wear_limit;
    logic [7:0] cfg_byte;
    int num_errors;
    int total_checks;

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // long busy window lets a second sequence land inside it
    flash_quad_cfg #(.CFG_WRITE_TIME_NS(8000)) dut (
        .core_clk(core_clk), .rst(rst), .factory_init(factory_init), .sclk(sclk),
        .cs_n(cs_n), .si(si), .soft_reset_cmd(soft_reset_cmd),
        .quad_opcode_hit(quad_opcode_hit), .so_out(so_out), .so_oe(so_oe),
        .ready_flag(ready_flag), .quad_io_enable_bit(quad_io_enable_bit),
        .pin_ctrl_en(pin_ctrl_en), .io23_data_en(io23_data_en),
        .quad_cmd_accept(quad_cmd_accept), .quad_cmd_reject(quad_cmd_reject),
        .cfg_byte(cfg_byte), .wear_limit(wear_limit)
    );
    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_ready(input logic lvl, input int lim);
        int k;
        k = 0;
        while (ready_flag !== lvl && k < lim) begin
            @(posedge core_clk);
            k++;
        end
        if (ready_flag !== lvl) begin
            num_errors++;
            $display("[FAIL] ready wait expected %b seen %b", lvl, ready_flag);
            tally_and_finish();
        end
    endtask

    task automatic read_cfg(input logic q);
        logic [15:0] rd;
        wait_ready(1'b1, 1200); // poll ready first
        host.frame(40'h3F, 8, 16, rd);
        @(posedge core_clk);
        chk("cfg read", {2{q, 7'h08}}, rd);
        chk("cfg port", {q, 7'h08}, cfg_byte);
        chk("so float", 1'h0, so_oe);
        chk("pin roles", {q, ~q}, {io23_data_en, pin_ctrl_en});
        repeat (6) @(posedge core_clk);
    endtask

    task automatic write_cfg(input logic [7:0] b4, input logic q);
        logic [15:0] rd;
        host.frame({24'h3D2A81, b4}, 32, 0, rd);
        wait_ready(1'b0, 20); // busy shows
        wait_ready(1'b1, 1200);
        repeat (2) @(posedge core_clk);
        chk("qe after write", q, quad_io_enable_bit);
        chk("cfg after write", {q, 7'h08}, cfg_byte);
        chk("wear limit", 1'h0, wear_limit);
    endtask

    task automatic bad_seq(input logic [39:0] d, input int n);
        logic q;
        logic [15:0] rd;
        q = quad_io_enable_bit;
        host.frame(d, n, 0, rd);
        repeat (20) @(posedge core_clk);
        chk("ready after bad", 1'h1, ready_flag);
        chk("qe after bad", q, quad_io_enable_bit);
    endtask

    task automatic busy_ignore();
        logic [15:0] rd;
        host.frame(40'h3D2A8166, 32, 0, rd);
        wait_ready(1'b0, 20);
        host.frame(40'h3D2A8167, 32, 0, rd); // lands inside the busy window
        wait_ready(1'b1, 1200);
        repeat (30) @(posedge core_clk);
        chk("busy ignore qe", 1'h1, quad_io_enable_bit);
        chk("busy ignore rdy", 1'h1, ready_flag);
    endtask

    task automatic opcode_hit(input logic q);
        @(posedge core_clk);
        quad_opcode_hit <= 1'b1;
        @(posedge core_clk);
        quad_opcode_hit <= 1'b0;
        #1;
        chk("quad answer", {q, ~q}, {quad_cmd_accept, quad_cmd_reject});
        @(posedge core_clk);
        #1;
        chk("quad pulse end", 2'h0, {quad_cmd_accept, quad_cmd_reject});
        @(posedge core_clk);
    endtask

    task automatic soft_reset(input logic q);
        logic [15:0] rd;
        soft_reset_cmd <= 1'b1;
        // held across the frame end, so the armed disable sequence is dropped
        host.frame(40'h3D2A8167, 32, 0, rd);
        repeat (8) @(posedge core_clk);
        soft_reset_cmd <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("ready after soft reset", 1'h1, ready_flag);
        chk("qe after soft reset", q, quad_io_enable_bit);
    endtask

    task automatic power_reset(input logic q);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("qe after reset", q, quad_io_enable_bit);
        chk("cfg after reset", {q, 7'h08}, cfg_byte);
    endtask

    task automatic partial_read();
        logic [15:0] rd;
        host.frame(40'h3F, 8, 3, rd);
        @(posedge core_clk);
        chk("partial read", 16'h0004, rd);
        chk("partial float", 1'h0, so_oe);
    endtask

    initial begin
        rst = 1'b1;
        factory_init = 1'b1;
        soft_reset_cmd = 1'b0;
        quad_opcode_hit = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        factory_init <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("shipped qe", 1'h0, quad_io_enable_bit);
        read_cfg(1'b0);
        opcode_hit(1'b0);
        write_cfg(8'h66, 1'b1);
        read_cfg(1'b1);
        opcode_hit(1'b1);
        soft_reset(1'b1);
        power_reset(1'b1);
        read_cfg(1'b1);
        bad_seq(40'h3D2A8167 >> 1, 31);
        bad_seq({32'h3D2A8167, 1'b0}, 33);
        bad_seq(40'h3D2A8067, 32);
        bad_seq(40'h3D2A8168, 32);
        write_cfg(8'h67, 1'b0);
        busy_ignore();
        partial_read();
        tally_and_finish();
    end
endmodule // tb_top
